// File: verilog/oload_pkg.sv
// Constants and register map for the off-state open-load block.
// Assumes a 10 MHz mclk and an APB master with 32-bit data.
package oload_pkg;
    localparam int NUM_CH = 5;
    localparam int CLK_KHZ = 10000;
    // Times as printed, in their own units
    localparam int WINDOW_US_X10 = 12000;     // 1.2 ms typical
    localparam int FAULT_NS = 3300;           // 3.3 us typical
    localparam int ONFILT_SHORT_US = 64;      // 64 us typical
    localparam int ONFILT_LONG_US = 2000;     // 2.0 ms typical
    localparam int LED_MAX_US = 2600;         // 2.6 ms maximum
    localparam int WINDOW_CYC = WINDOW_US_X10 * (CLK_KHZ / 1000) / 10;
    localparam int FAULT_CYC = (FAULT_NS * (CLK_KHZ / 1000) + 999) / 1000;
    localparam int ONFILT_SHORT_CYC = ONFILT_SHORT_US * (CLK_KHZ / 1000);
    localparam int ONFILT_LONG_CYC = ONFILT_LONG_US * (CLK_KHZ / 1000);
    localparam int LED_MAX_CYC = LED_MAX_US * (CLK_KHZ / 1000);
    localparam int DUTY_MIN_LOWMID = 18;
    localparam int DUTY_MIN_HIGH = 17;
    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_QUICK = 12'h004;
    localparam logic [11:0] ADDR_CH0 = 12'h008;
    localparam logic [11:0] ADDR_IO = 12'h01c;
    localparam logic [11:0] ADDR_FILT = 12'h020;
    // Control register fields
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_ACTIVE_BIT = 8;
    // Channel status fields
    localparam int ST_OFFOPEN = 0;
    localparam int ST_ONOPEN = 1;
    localparam int ST_OC_LSB = 2;
    localparam int ST_OTW = 5;
    localparam int ST_OTS = 6;
    localparam int ST_GOPEN = 8;
    localparam int ST_GOVL = 9;
    localparam int ST_GDEV = 10;
    // Quick/IO status fields
    localparam int Q_GOPEN = 8;
    localparam int IO_UV = 8;
    typedef enum logic [1:0] {
        DIAG_IDLE,
        DIAG_RUN,
        DIAG_FAULT
    } diag_state_e;
endpackage : oload_pkg

// File: verilog/diag_ch_if.sv
// Per-channel link between the sequencer and the flag store.
// Assumes both ends share mclk.
`timescale 1ns/1ps
interface diag_ch_if #(
    parameter int N = 5
);
    logic [N-1:0] open_set;
    logic [N-1:0] rd_clear;
    logic [N-1:0] open_flag;
    modport seq (output open_set, rd_clear, input open_flag);
    modport store (input open_set, rd_clear, output open_flag);
endinterface : diag_ch_if

// File: verilog/diag_timer.sv
// Down-counter giving a one-cycle done pulse after a load.
// Assumes load and abort come from logic on mclk.
`timescale 1ns/1ps
module diag_timer #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    input wire logic abort,
    output logic done
);
    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic run_q, run_d;
    logic done_q, done_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (abort) begin
            run_d = 1'b0;
        end else if (load) begin
            cnt_d = count;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q <= WIDTH'(1)) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
endmodule : diag_timer

// File: verilog/oload_flags.sv
// Sticky off-state open flags, cleared by a status read.
// Assumes set and clear strobes on mclk.
`timescale 1ns/1ps
module oload_flags #(
    parameter int N = 5
) (
    input wire logic mclk,
    input wire logic rst_n,
    diag_ch_if.store ch
);
    logic [N-1:0] flag_q, flag_d;

    // Set wins over a coincident read
    always_comb begin
        flag_d = (flag_q & ~ch.rd_clear) | ch.open_set;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign ch.open_flag = flag_q;
endmodule : oload_flags

// File: verilog/offstate_openload_detect.sv
// Off-state open-load diagnosis for five high-side outputs, APB slave.
// Assumes pin-level fault and comparator inputs are asynchronous.
//
// Notes on behaviour
// - Per-channel enable bit, zero after reset.
// - Writing one starts a timed check window.
// - Control writes ignored while any check runs.
// - Selected channels start together at write end.
// - Output switched on with test current limit.
// - Limit reached: off, enable cleared, no flags.
// - Window expired: off, enable cleared, flag set.
// - Protection, feedback and sync settings untouched.
// - Open result sets summary, global, channel bit.
// - Open flag latched until channel status read.
// - Supply or thermal fault aborts, filtered switch-off.
// - On-state filter 64 us or 2 ms: select stored, no filter applied.
// - LED check completes within 2.6 ms.
// - Output level bits real time, unlatched.
// - Level bits undefined under undervoltage.
// - Summary bit ORs all channel fault flags.
// - Global flags in quick and channel words, clear with sources.
`timescale 1ns/1ps
module offstate_openload_detect #(
    parameter int N = oload_pkg::NUM_CH,
    parameter int WINDOW_CYCLES = oload_pkg::WINDOW_CYC,
    parameter int FAULT_CYCLES = oload_pkg::FAULT_CYC,
    parameter int ONFILT_SHORT = oload_pkg::ONFILT_SHORT_CYC,
    parameter int ONFILT_LONG = oload_pkg::ONFILT_LONG_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N-1:0] test_limit_hit,
    input wire logic [N-1:0] output_level_bit,
    input wire logic overtemp_shutdown_in,
    input wire logic undervoltage_in,
    input wire logic pump_fault_in,
    input wire logic [N-1:0] onstate_open_in,
    input wire logic [N-1:0] overtemp_warning_in,
    input wire logic [3*N-1:0] overcurrent_code_in,
    output logic [N-1:0] test_drive_on,
    output logic diag_active
);
    localparam int TW = 16;
    initial begin
        if (N < 1 || N > 8) $error("N must be 1 to 8");
        if (WINDOW_CYCLES < 1 || WINDOW_CYCLES >= (1 << TW))
            $error("WINDOW_CYCLES out of range");
        if (FAULT_CYCLES < 1 || FAULT_CYCLES >= (1 << TW))
            $error("FAULT_CYCLES out of range");
        if (ONFILT_SHORT < 1 || ONFILT_SHORT >= ONFILT_LONG)
            $error("ONFILT_SHORT out of range");
        if (ONFILT_LONG > oload_pkg::LED_MAX_CYC)
            $error("ONFILT_LONG beyond LED limit");
    end

    // Two-stage synchronisers for every pin input
    localparam int SW = 3 * N + 3;
    logic [SW-1:0] sy1_q, sy2_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {test_limit_hit, output_level_bit, onstate_open_in,
                      overtemp_shutdown_in, undervoltage_in, pump_fault_in};
            sy2_q <= sy1_q;
        end
    end
    logic [N-1:0] limit_s, level_s, onopen_s;
    logic ots_s, uv_s, cp_s;
    assign {limit_s, level_s, onopen_s, ots_s, uv_s, cp_s} = sy2_q;

    logic [3*N+N-1:0] sy3_q, sy4_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sy3_q <= '0;
            sy4_q <= '0;
        end else begin
            sy3_q <= {overcurrent_code_in, overtemp_warning_in};
            sy4_q <= sy3_q;
        end
    end
    logic [3*N-1:0] oc_s;
    logic [N-1:0] otw_s;
    assign {oc_s, otw_s} = sy4_q;

    // APB: zero-wait, write takes effect at access phase
    logic acc;
    logic wr_ctrl, wr_filt;
    assign acc = psel && penable;
    assign wr_ctrl = acc && pwrite && paddr == oload_pkg::ADDR_CTRL;
    assign wr_filt = acc && pwrite && paddr == oload_pkg::ADDR_FILT;

    function automatic logic is_ch_addr(input logic [11:0] a, input int c);
        is_ch_addr = a == oload_pkg::ADDR_CH0 + 12'(4 * c);
    endfunction : is_ch_addr

    // Sequencer state
    oload_pkg::diag_state_e st_q, st_d;
    logic [N-1:0] en_q, en_d;
    logic [N-1:0] drive_q, drive_d;
    logic [N-1:0] filt_sel_q, filt_sel_d;
    logic fault_q, fault_d;
    logic active_q, active_d;
    logic win_load, win_done, flt_load, flt_done;
    logic [N-1:0] rd_clr;
    diag_ch_if #(.N(N)) chl();

    logic fault_now;
    assign fault_now = ots_s || uv_s || cp_s;

    always_comb begin
        st_d = st_q;
        en_d = en_q;
        drive_d = drive_q;
        filt_sel_d = filt_sel_q;
        fault_d = fault_q;
        win_load = 1'b0;
        flt_load = 1'b0;
        chl.open_set = '0;
        // Clear first so a coincident new fault report wins
        if (fault_q && !fault_now) begin
            fault_d = 1'b0;
        end
        if (wr_filt) begin
            filt_sel_d = pwdata[N-1:0];
        end
        case (st_q)
            oload_pkg::DIAG_IDLE: begin
                // Start on the closing strobe of the write
                if (wr_ctrl) begin
                    en_d = pwdata[oload_pkg::CTRL_EN_LSB +: N];
                    if (pwdata[oload_pkg::CTRL_EN_LSB +: N] != '0) begin
                        drive_d = pwdata[oload_pkg::CTRL_EN_LSB +: N];
                        win_load = 1'b1;
                        st_d = oload_pkg::DIAG_RUN;
                    end
                end
            end
            oload_pkg::DIAG_RUN: begin
                // Control writes ignored here: no restart, no abort
                for (int c = 0; c < N; c++) begin
                    if (drive_q[c] && limit_s[c]) begin
                        drive_d[c] = 1'b0;
                        en_d[c] = 1'b0;
                    end
                end
                if (fault_now) begin
                    flt_load = 1'b1;
                    st_d = oload_pkg::DIAG_FAULT;
                end else if (win_done) begin
                    chl.open_set = drive_d;
                    drive_d = '0;
                    en_d = '0;
                    st_d = oload_pkg::DIAG_IDLE;
                end
            end
            oload_pkg::DIAG_FAULT: begin
                // Abort reports only the fault, never an open result
                if (flt_done) begin
                    drive_d = '0;
                    en_d = '0;
                    fault_d = 1'b1;
                    st_d = oload_pkg::DIAG_IDLE;
                end
            end
            default: begin
                st_d = oload_pkg::DIAG_IDLE;
            end
        endcase
        active_d = st_d != oload_pkg::DIAG_IDLE;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= oload_pkg::DIAG_IDLE;
            en_q <= '0;
            drive_q <= '0;
            filt_sel_q <= '0;
            fault_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            st_q <= st_d;
            en_q <= en_d;
            drive_q <= drive_d;
            filt_sel_q <= filt_sel_d;
            fault_q <= fault_d;
            active_q <= active_d;
        end
    end

    diag_timer #(.WIDTH(TW)) win_tmr (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(win_load),
        .count(TW'(WINDOW_CYCLES)),
        .abort(flt_load),
        .done(win_done)
    );

    diag_timer #(.WIDTH(TW)) flt_tmr (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(flt_load),
        .count(TW'(FAULT_CYCLES)),
        .abort(1'b0),
        .done(flt_done)
    );

    // Read of a channel status word clears its open flag
    always_comb begin
        for (int c = 0; c < N; c++) begin
            rd_clr[c] = acc && !pwrite && is_ch_addr(paddr, c);
        end
        chl.rd_clear = rd_clr;
    end

    oload_flags #(.N(N)) flags (
        .mclk(mclk),
        .rst_n(rst_n),
        .ch(chl.store)
    );

    // Summary and global flags
    logic [N-1:0] summary;
    logic gopen, govl, gdev;
    always_comb begin
        for (int c = 0; c < N; c++) begin
            summary[c] = (|oc_s[3*c +: 3]) | otw_s[c] | ots_s | onopen_s[c]
                       | chl.open_flag[c];
        end
        gopen = |chl.open_flag || |onopen_s;
        govl = (|oc_s) || ots_s;
        gdev = uv_s || cp_s || fault_q;
    end

    function automatic logic [31:0] glob(input logic o, input logic v,
                                         input logic d);
        glob = '0;
        glob[oload_pkg::ST_GOPEN] = o;
        glob[oload_pkg::ST_GOVL] = v;
        glob[oload_pkg::ST_GDEV] = d;
    endfunction : glob

    // Read mux; unmapped reads give zero with pslverr
    logic [31:0] rdata_d, rdata_q;
    logic err_d, err_q;
    always_comb begin
        rdata_d = '0;
        err_d = 1'b0;
        if (paddr == oload_pkg::ADDR_CTRL) begin
            rdata_d[oload_pkg::CTRL_EN_LSB +: N] = en_q;
            rdata_d[oload_pkg::CTRL_ACTIVE_BIT] = st_q != oload_pkg::DIAG_IDLE;
        end else if (paddr == oload_pkg::ADDR_QUICK) begin
            rdata_d = glob(gopen, govl, gdev);
            rdata_d[N-1:0] = summary;
        end else if (paddr >= oload_pkg::ADDR_CH0 &&
                     paddr < oload_pkg::ADDR_CH0 + 12'(4 * N) &&
                     paddr[1:0] == 2'b00) begin
            rdata_d = glob(gopen, govl, gdev);
            for (int c = 0; c < N; c++) begin
                if (is_ch_addr(paddr, c)) begin
                    rdata_d[oload_pkg::ST_OFFOPEN] = chl.open_flag[c];
                    rdata_d[oload_pkg::ST_ONOPEN] = onopen_s[c];
                    rdata_d[oload_pkg::ST_OC_LSB +: 3] = oc_s[3*c +: 3];
                    rdata_d[oload_pkg::ST_OTW] = otw_s[c];
                    rdata_d[oload_pkg::ST_OTS] = ots_s;
                end
            end
        end else if (paddr == oload_pkg::ADDR_IO) begin
            // Meaningless under undervoltage; flag shown beside them
            rdata_d[N-1:0] = level_s;
            rdata_d[oload_pkg::IO_UV] = uv_s;
        end else if (paddr == oload_pkg::ADDR_FILT) begin
            rdata_d[N-1:0] = filt_sel_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // Registered data valid in the cycle after setup, together with pready
    logic rdy_d, rdy_q;
    assign rdy_d = psel && !penable;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= '0;
            err_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d && psel && !penable;
            rdy_q <= rdy_d;
        end
    end

    // On-state filter length chosen per channel, only stored and read back; no on-state path uses it
    logic [N-1:0] unused_sel;
    assign unused_sel = '0;

    assign prdata = rdata_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    // Test drive only; protection settings stay with their own logic
    assign test_drive_on = drive_q;
    assign diag_active = active_q;
endmodule : offstate_openload_detect

// File: verif/oload_monitor.sv
// Checker for the off-state open-load block, bound to its top ports.
// Assumes one clock, mclk, and a synchronous active-low rst_n.
`timescale 1ns/1ps
module oload_monitor #(
    parameter int N = 5,
    parameter int WINDOW_CYCLES = 50,
    parameter int FAULT_CYCLES = 5
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic [N-1:0] test_limit_hit,
    input wire logic overtemp_shutdown_in,
    input wire logic undervoltage_in,
    input wire logic pump_fault_in,
    input wire logic [N-1:0] test_drive_on,
    input wire logic diag_active
);
    // Slack covers the two sync flops and the state step
    localparam int FMAX = FAULT_CYCLES + 8;
    logic [15:0] run_q;
    logic fault;
    logic ctrl_wr;
    logic rd_acc;
    assign fault = overtemp_shutdown_in | undervoltage_in | pump_fault_in;
    assign ctrl_wr = psel && penable && pready && pwrite
        && paddr == oload_pkg::ADDR_CTRL;
    assign rd_acc = psel && penable && pready && !pwrite;
    always_ff @(posedge mclk) begin
        if (!rst_n || !diag_active) begin
            run_q <= 16'h0000;
        end else begin
            run_q <= run_q + 16'h0001;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_IDLE_OFF:
        assert property (!diag_active |-> test_drive_on == '0)
        else $error("output driven while no check runs");
    AST_WINDOW_MAX:
        assert property (int'(run_q) <= WINDOW_CYCLES + 8)
        else $error("check window overran");
    AST_START_TOGETHER:
        assert property (ctrl_wr && !diag_active && !fault
            && pwdata[N-1:0] != '0 |=> test_drive_on == $past(pwdata[N-1:0]))
        else $error("selected channels did not start together");
    AST_NO_RESTART:
        assert property (ctrl_wr && diag_active
            |=> (test_drive_on & ~$past(test_drive_on)) == '0)
        else $error("write during a check changed the drive");
    AST_LIMIT_STOP:
        assert property (not ((|(test_drive_on & test_limit_hit)) [*6]))
        else $error("output kept on after limit reached");
    AST_FAULT_OFF:
        assert property ($rose(fault) |-> ##[1:FMAX] test_drive_on == '0)
        else $error("fault did not switch outputs off");
    AST_FAULT_FILTER:
        assert property ($rose(fault) && (|test_drive_on)
            && !(|test_limit_hit) |=> (|test_drive_on) [*3])
        else $error("fault switch-off skipped its filter");
    AST_QUICK_GLOBAL:
        assert property (rd_acc && paddr == oload_pkg::ADDR_QUICK
            && prdata[oload_pkg::Q_GOPEN] |-> prdata[N-1:0] != '0)
        else $error("global open set with no channel summary");
    AST_CH_GLOBAL:
        assert property (rd_acc && paddr >= oload_pkg::ADDR_CH0
            && paddr < oload_pkg::ADDR_IO && prdata[oload_pkg::ST_OFFOPEN]
            |-> prdata[oload_pkg::ST_GOPEN])
        else $error("channel open flag without global flag");
endmodule : oload_monitor

bind offstate_openload_detect oload_monitor #(.N(N),
    .WINDOW_CYCLES(WINDOW_CYCLES), .FAULT_CYCLES(FAULT_CYCLES))
    i_oload_monitor (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .test_limit_hit(test_limit_hit),
    .overtemp_shutdown_in(overtemp_shutdown_in),
    .undervoltage_in(undervoltage_in), .pump_fault_in(pump_fault_in),
    .test_drive_on(test_drive_on), .diag_active(diag_active));

// File: verif/load_model.sv
// Power stage and loads behind the five outputs.
// Assumes test_drive_on comes from the block on mclk.
`timescale 1ns/1ps
module load_model (
    input wire logic mclk,
    input wire logic [4:0] test_drive_on,
    input wire logic [4:0] load_mask,
    input wire logic [4:0] level_set,
    output logic [4:0] test_limit_hit,
    output logic [4:0] output_level_bit
);
    logic [4:0] hit_q = 5'h00;
    logic [2:0] on_cnt [5] = '{default: 3'h0};
    // Current builds up for a few cycles before the limit trips
    always @(posedge mclk) begin
        for (int c = 0; c < 5; c++) begin
            if (test_drive_on[c] !== 1'b1) begin
                on_cnt[c] <= 3'h0;
                hit_q[c] <= 1'b0;
            end else if (on_cnt[c] != 3'h4) begin
                on_cnt[c] <= on_cnt[c] + 3'h1;
            end else begin
                hit_q[c] <= load_mask[c];
            end
        end
    end
    assign test_limit_hit = hit_q;
    // A driven output sits above half supply
    assign output_level_bit = level_set | test_drive_on;
endmodule : load_model

// File: verif/offstate_openload_detect_bench.sv
// Self-checking bench for the off-state open-load block.
// Assumes the design sources and the load model are compiled first.
`timescale 1ns/1ps
module offstate_openload_detect_bench;
    typedef struct {logic [4:0] en; logic [4:0] load; logic [4:0] exp;} row_s;
    row_s rows [5] = '{'{5'h00, 5'h00, 5'h00}, '{5'h1f, 5'h00, 5'h1f},
        '{5'h1f, 5'h1f, 5'h00}, '{5'h05, 5'h04, 5'h01},
        '{5'h12, 5'h02, 5'h10}};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] hit, lvl, drive, load = 5'h00, level = 5'h00;
    logic [4:0] onopen = 5'h00, otw = 5'h00;
    logic [14:0] oc = 15'h0000;
    logic overtemp_shutdown_flag = 1'b0, uv = 1'b0, pump_fault_flag = 1'b0, active;
    logic [31:0] rdata_q;
    logic err_q;
    int err_total = 0;
    int comparisons = 0;
    always #50 mclk = ~mclk;
    offstate_openload_detect #(.WINDOW_CYCLES(50), .FAULT_CYCLES(5))
    i_offstate_openload_detect (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .test_limit_hit(hit), .output_level_bit(lvl),
        .overtemp_shutdown_in(overtemp_shutdown_flag), .undervoltage_in(uv),
        .pump_fault_in(pump_fault_flag), .onstate_open_in(onopen),
        .overtemp_warning_in(otw), .overcurrent_code_in(oc),
        .test_drive_on(drive), .diag_active(active));
    load_model i_load_model (.mclk(mclk), .test_drive_on(drive),
        .load_mask(load), .level_set(level), .test_limit_hit(hit),
        .output_level_bit(lvl));
    task automatic give_verdict;
        $display("counts: %0d compared, %0d mismatched", comparisons,
            err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            give_verdict();
        end
    endtask : apb
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (active !== 1'b0 && n < 300);
        if (n >= 300) begin
            err_total++;
            give_verdict();
        end
    endtask : wait_idle
    task automatic clear_all;
        for (int c = 0; c < 5; c++) begin
            rd(12'(oload_pkg::ADDR_CH0 + 4 * c));
        end
    endtask : clear_all
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(oload_pkg::ADDR_CTRL);
        check("ctrl after reset", rdata_q, 32'h0);
        rd(oload_pkg::ADDR_QUICK);
        check("quick after reset", rdata_q, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            load <= rows[i].load;
            apb(1'b1, oload_pkg::ADDR_CTRL, {27'h0, rows[i].en});
            wait_idle();
            rd(oload_pkg::ADDR_QUICK);
            check("quick", rdata_q[8:0], {|rows[i].exp, 3'h0, rows[i].exp});
            rd(oload_pkg::ADDR_CTRL);
            check("enable cleared", rdata_q[4:0], 5'h00);
            for (int c = 0; c < 5; c++) begin
                rd(12'(oload_pkg::ADDR_CH0 + 4 * c));
                check("channel open", rdata_q[0], rows[i].exp[c]);
            end
            rd(oload_pkg::ADDR_QUICK);
            check("quick cleared", rdata_q[8:0], 9'h0);
            $display("test row %0d done", i);
        end
        load <= 5'h00;
        apb(1'b1, oload_pkg::ADDR_CTRL, 32'h1f);
        apb(1'b1, oload_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, oload_pkg::ADDR_CTRL, 32'h03);
        check("drive kept", drive, 5'h1f);
        wait_idle();
        rd(oload_pkg::ADDR_QUICK);
        check("quick after ignored", rdata_q[8:0], 9'h11f);
        clear_all();
        $display("test ignored writes done");
        for (int f = 0; f < 3; f++) begin
            apb(1'b1, oload_pkg::ADDR_CTRL, 32'h07);
            repeat (4) @(posedge mclk);
            {overtemp_shutdown_flag, uv, pump_fault_flag} <= 3'h1 << f;
            wait_idle();
            check("drive after fault", drive, 5'h00);
            rd(oload_pkg::ADDR_CH0);
            check("fault status", rdata_q[10:0] & 11'h401, 11'h400);
            rd(oload_pkg::ADDR_IO);
            check("uv shown", rdata_q[8], f == 1);
            {overtemp_shutdown_flag, uv, pump_fault_flag} <= 3'h0;
            repeat (6) @(posedge mclk);
            rd(oload_pkg::ADDR_QUICK);
            check("no open after fault", rdata_q[8:0], 9'h0);
            clear_all();
        end
        $display("test fault abort done");
        onopen <= 5'h01;
        otw <= 5'h02;
        oc <= 15'h0040;
        repeat (4) @(posedge mclk);
        rd(oload_pkg::ADDR_QUICK);
        check("summary or", rdata_q[4:0], 5'h07);
        onopen <= 5'h00;
        otw <= 5'h00;
        oc <= 15'h0000;
        repeat (4) @(posedge mclk);
        clear_all();
        $display("test summary done");
        for (int k = 0; k < 2; k++) begin
            level <= k ? 5'h0a : 5'h15;
            repeat (4) @(posedge mclk);
            rd(oload_pkg::ADDR_IO);
            check("level bits", rdata_q[4:0], k ? 5'h0a : 5'h15);
        end
        apb(1'b1, oload_pkg::ADDR_FILT, 32'h15);
        rd(oload_pkg::ADDR_FILT);
        check("filter select", rdata_q, 32'h15);
        check("duty floors", {8'(oload_pkg::DUTY_MIN_LOWMID),
            8'(oload_pkg::DUTY_MIN_HIGH)}, 32'h1211);
        rd(12'h0f0);
        check("unmapped error", err_q, 1'b1);
        check("unmapped data", rdata_q, 32'h0);
        $display("test levels and unmapped done");
        give_verdict();
    end
endmodule : offstate_openload_detect_bench
